// *** include/aem_pkg.sv ***
// Package of constants and carrier types for the alarm and event manager.
package aem_pkg;

	// ==========================================================
	// Register byte offsets on the bus.
	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_OV_LIMIT   = 8'h04;
	localparam logic [7:0] OFS_OC_LIMIT   = 8'h08;
	localparam logic [7:0] OFS_OP_LIMIT   = 8'h0C;
	localparam logic [7:0] OFS_EVENT_CFG  = 8'h10;
	localparam logic [7:0] OFS_EV_HV_THR  = 8'h14;
	localparam logic [7:0] OFS_EV_LV_THR  = 8'h18;
	localparam logic [7:0] OFS_EV_HC_THR  = 8'h1C;
	localparam logic [7:0] OFS_ALARMS     = 8'h20;
	localparam logic [7:0] OFS_EVENTS     = 8'h24;
	localparam logic [7:0] OFS_STATE      = 8'h28;

	// ==========================================================
	// Control register field positions.
	localparam int CTL_OUTPUT_ON  = 0;
	localparam int CTL_BEEP_EN    = 1;
	localparam int CTL_MS_MODE    = 2;
	localparam int CTL_PF_RESTART = 3;
	localparam int CTL_OT_RESTART = 4;
	localparam int CTL_MS_REINIT  = 5;
	localparam int CTL_WIDTH      = 5;
	localparam logic [4:0] CTL_RESET = 5'h0_0;

	// ==========================================================
	// Alarm flag positions in the alarm status register.
	localparam int ALM_OV     = 0;
	localparam int ALM_OC     = 1;
	localparam int ALM_OP     = 2;
	localparam int ALM_PF     = 3;
	localparam int ALM_OT     = 4;
	localparam int ALM_LINK   = 5;
	localparam int ALM_SAFE   = 6;
	localparam int ALM_SHARE  = 7;
	localparam int ALM_EVENT  = 8;
	localparam int ALM_COUNT  = 9;
	// Alarms that switch the output off.
	localparam logic [8:0] ALM_OFF_MASK    = 9'h17F;
	// Alarms that also show on the analog interface line.
	localparam logic [8:0] ALM_ANALOG_MASK = 9'h0FF;

	// ==========================================================
	// User event numbering and action codes.
	localparam int EV_HIGH_VOLT = 0;
	localparam int EV_LOW_VOLT  = 1;
	localparam int EV_HIGH_CURR = 2;
	localparam int EV_COUNT     = 3;
	typedef enum logic [1:0] {
		ACT_NONE    = 2'h0,
		ACT_SIGNAL  = 2'h1,
		ACT_WARNING = 2'h2,
		ACT_ALARM   = 2'h3
	} aem_action_t;
	localparam logic [5:0] EVENT_CFG_RESET = 6'h0_0;

	// ==========================================================
	// Measurement and limit scaling.
	localparam int MEAS_W     = 16;
	localparam int LIMIT_NUM  = 11;
	localparam int LIMIT_DEN  = 10;
	localparam int SAFE_NUM   = 101;
	localparam int SAFE_DEN   = 100;

	// ==========================================================
	// Timing of the supply-failure recovery.
	localparam longint CLOCK_HZ       = 64'd100_000_000;
	localparam longint PF_ACK_WAIT_S  = 64'd15;
	localparam longint PF_LOCK_WAIT_S = 64'd5;
	localparam logic [31:0] PF_ACK_CYCLES  =
		32'(PF_ACK_WAIT_S * CLOCK_HZ);
	localparam logic [31:0] PF_LOCK_CYCLES =
		32'(PF_LOCK_WAIT_S * CLOCK_HZ);

	// ==========================================================
	// Carrier types.
	typedef struct packed {
		logic        hsel;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] haddr;
		logic        hready;
	} aem_ahb_t;

	typedef struct packed {
		logic [15:0] voltage;
		logic [15:0] current;
		logic [15:0] power;
	} aem_meas_t;

	typedef struct packed {
		logic supply_bad;
		logic over_temp;
		logic slave_lost;
		logic share_weak;
		logic share_linked;
	} aem_hw_t;

endpackage : aem_pkg

// *** rtl/aem_hold_timer.sv ***
// Reloadable down counter that reports busy until it runs out.
module aem_hold_timer #(
	parameter logic [31:0] CYCLES = 32'h0000_0010
) (
	// Clock and reset.
	input  wire logic i_clock,
	input  wire logic i_reset_n,
	// Hold the counter at full while high.
	input  wire logic i_hold,
	// High while the wait is still running.
	output logic      o_busy
);

	// Remaining cycles of the wait.
	logic [31:0] remain;

	// ==========================================================
	// Counter: reload while held, then count down to zero.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			remain <= 32'h0000_0000;
		end else if (i_hold) begin
			remain <= CYCLES;
		end else if (remain != 32'h0000_0000) begin
			remain <= remain - 32'h0000_0001;
		end
	end

	// Busy flag from a flip-flop so it is clean for the gating logic.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= i_hold || (remain > 32'h0000_0001);
		end
	end

endmodule : aem_hold_timer

// *** rtl/aem_top.sv ***
// Alarm and event manager for the output stage, with AHB-Lite registers.
module aem_top #(
	parameter logic [15:0] NOM_VOLTAGE = 16'h2710,
	parameter logic [15:0] NOM_CURRENT = 16'h2710,
	parameter logic [15:0] NOM_POWER   = 16'h2710,
	parameter logic [31:0] PF_ACK_CYC  = aem_pkg::PF_ACK_CYCLES,
	parameter logic [31:0] PF_LOCK_CYC = aem_pkg::PF_LOCK_CYCLES
) (
	// Clock and reset.
	input  wire logic             i_clock,
	input  wire logic             i_reset_n,
	// AHB-Lite slave port.
	input  wire aem_pkg::aem_ahb_t i_ahb,
	input  wire logic [31:0]      i_hwdata,
	output logic [31:0]           o_hrdata,
	output logic                  o_hreadyout,
	output logic                  o_hresp,
	// Measured output values.
	input  wire aem_pkg::aem_meas_t i_meas,
	// Hardware alarm sources.
	input  wire aem_pkg::aem_hw_t  i_hw,
	// Acknowledge pulses from panel and remote control.
	input  wire logic             i_ack_panel,
	input  wire logic             i_ack_remote,
	// Output-stage and indication outputs.
	output logic                  o_dc_enable,
	output logic                  o_beep,
	output logic                  o_analog_alarm,
	output logic                  o_status_ind,
	output logic                  o_warning
);

	// ==========================================================
	// Declarations.
	logic [4:0]  ctl;            // Control bits.
	logic [15:0] ov_limit;       // Overvoltage trip threshold.
	logic [15:0] oc_limit;       // Overcurrent trip threshold.
	logic [15:0] op_limit;       // Overpower trip threshold.
	logic [5:0]  ev_cfg;         // Two action bits per user event.
	logic [15:0] ev_thr [aem_pkg::EV_COUNT]; // Event thresholds.
	logic [8:0]  alarm;          // Latched pending alarms.
	logic [8:0]  alarm_cond;     // Live alarm conditions.
	logic [8:0]  alarm_clr;      // Acknowledge requests this cycle.
	logic [2:0]  ev_hit;         // Event conditions while output on.
	logic [2:0]  ev_ind;         // Posted status indications.
	logic [2:0]  ev_warn;        // Pending warnings.
	logic [2:0]  ev_warn_clr;    // Warning acknowledge requests.
	logic [2:0]  ev_alarm_hit;   // Events with action alarm firing.
	logic        ms_reinit;      // One-cycle reinit pulse.
	logic        pf_ack_busy;    // Acknowledge window still running.
	logic        pf_lock_busy;   // Re-enable lock still running.
	logic        dph_write;      // Write data phase pending.
	logic        dph_read;       // Read data phase pending.
	logic [7:0]  dph_addr;       // Address of pending data phase.
	logic        addr_ok;        // Address phase accepted.
	logic [8:0]  kill_mask;      // New alarms that drop the on request.
	logic        wr_go;          // Write data present this cycle.

	// Returns the action code of one user event.
	function automatic aem_pkg::aem_action_t ev_action(
		input logic [5:0] cfg,
		input int         idx
	);
		ev_action = aem_pkg::aem_action_t'(cfg[2*idx +: 2]);
	endfunction : ev_action

	// Clamps a written threshold to 1.1 times the nominal value.
	function automatic logic [15:0] clamp_limit(
		input logic [31:0] wdata,
		input logic [15:0] nominal
	);
		logic [31:0] top;
		top = 32'(nominal) * 32'(aem_pkg::LIMIT_NUM)
			/ 32'(aem_pkg::LIMIT_DEN);
		clamp_limit = (wdata > top) ? top[15:0] : wdata[15:0];
	endfunction : clamp_limit

	// ==========================================================
	// Bus front end: accept only whole-word transfers, nonsequential or sequential.
	assign addr_ok = i_ahb.hsel && i_ahb.htrans[1] && i_ahb.hready
		&& (i_ahb.hsize == 3'h2);
	assign wr_go = dph_write;

	// Data phase tracking; reads take one wait state so that a write
	// just before them is seen.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dph_write   <= 1'b0;
			dph_read    <= 1'b0;
			dph_addr    <= 8'h00;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			dph_write   <= addr_ok && i_ahb.hwrite;
			dph_read    <= addr_ok && !i_ahb.hwrite;
			o_hreadyout <= !(addr_ok && !i_ahb.hwrite);
			o_hresp     <= 1'b0;
			if (addr_ok) begin
				dph_addr <= i_ahb.haddr[7:0];
			end
		end
	end

	// Read data register; unmapped offsets read as zero.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_hrdata <= 32'h0000_0000;
		end else if (dph_read) begin
			unique case (dph_addr)
				aem_pkg::OFS_CONTROL:   o_hrdata <= 32'(ctl);
				aem_pkg::OFS_OV_LIMIT:  o_hrdata <= 32'(ov_limit);
				aem_pkg::OFS_OC_LIMIT:  o_hrdata <= 32'(oc_limit);
				aem_pkg::OFS_OP_LIMIT:  o_hrdata <= 32'(op_limit);
				aem_pkg::OFS_EVENT_CFG: o_hrdata <= 32'(ev_cfg);
				aem_pkg::OFS_EV_HV_THR: o_hrdata <= 32'(ev_thr[0]);
				aem_pkg::OFS_EV_LV_THR: o_hrdata <= 32'(ev_thr[1]);
				aem_pkg::OFS_EV_HC_THR: o_hrdata <= 32'(ev_thr[2]);
				aem_pkg::OFS_ALARMS:    o_hrdata <= 32'(alarm);
				aem_pkg::OFS_EVENTS:
					o_hrdata <= 32'({ev_warn, ev_ind});
				aem_pkg::OFS_STATE:
					o_hrdata <= 32'({pf_lock_busy, pf_ack_busy,
						o_dc_enable});
				default: o_hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Control register; a new output-disabling alarm drops the on
	// request unless its restart option lets the output come back.
	assign kill_mask = aem_pkg::ALM_OFF_MASK
		& ~(9'(ctl[aem_pkg::CTL_PF_RESTART]) << aem_pkg::ALM_PF)
		& ~(9'(ctl[aem_pkg::CTL_OT_RESTART]) << aem_pkg::ALM_OT);

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctl <= aem_pkg::CTL_RESET;
		end else begin
			if (wr_go && dph_addr == aem_pkg::OFS_CONTROL) begin
				ctl <= i_hwdata[4:0];
			end
			if (|(alarm_cond & ~alarm & kill_mask)) begin
				ctl[aem_pkg::CTL_OUTPUT_ON] <= 1'b0;
			end
		end
	end

	// Reinit of the master-slave system is a write-only pulse bit.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ms_reinit <= 1'b0;
		end else begin
			ms_reinit <= wr_go && dph_addr == aem_pkg::OFS_CONTROL
				&& i_hwdata[aem_pkg::CTL_MS_REINIT];
		end
	end

	// Protection thresholds, clamped to 1.1 times nominal on write.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ov_limit <= clamp_limit(32'hFFFF_FFFF, NOM_VOLTAGE);
			oc_limit <= clamp_limit(32'hFFFF_FFFF, NOM_CURRENT);
			op_limit <= clamp_limit(32'hFFFF_FFFF, NOM_POWER);
		end else if (wr_go) begin
			if (dph_addr == aem_pkg::OFS_OV_LIMIT) begin
				ov_limit <= clamp_limit(i_hwdata, NOM_VOLTAGE);
			end
			if (dph_addr == aem_pkg::OFS_OC_LIMIT) begin
				oc_limit <= clamp_limit(i_hwdata, NOM_CURRENT);
			end
			if (dph_addr == aem_pkg::OFS_OP_LIMIT) begin
				op_limit <= clamp_limit(i_hwdata, NOM_POWER);
			end
		end
	end

	// Event configuration; every event starts with action none.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ev_cfg    <= aem_pkg::EVENT_CFG_RESET;
			ev_thr[0] <= 16'h0000;
			ev_thr[1] <= 16'h0000;
			ev_thr[2] <= 16'h0000;
		end else if (wr_go) begin
			unique case (dph_addr)
				aem_pkg::OFS_EVENT_CFG: ev_cfg    <= i_hwdata[5:0];
				aem_pkg::OFS_EV_HV_THR: ev_thr[0] <= i_hwdata[15:0];
				aem_pkg::OFS_EV_LV_THR: ev_thr[1] <= i_hwdata[15:0];
				aem_pkg::OFS_EV_HC_THR: ev_thr[2] <= i_hwdata[15:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Supply-failure timers: acknowledge window, then output lock.
	aem_hold_timer #(
		.CYCLES (PF_ACK_CYC)
	) u_pf_ack (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_hold    (i_hw.supply_bad),
		.o_busy    (pf_ack_busy)
	);

	aem_hold_timer #(
		.CYCLES (PF_LOCK_CYC)
	) u_pf_lock (
		.i_clock   (i_clock),
		.i_reset_n (i_reset_n),
		.i_hold    (i_hw.supply_bad || pf_ack_busy),
		.o_busy    (pf_lock_busy)
	);

	// ==========================================================
	// Live alarm conditions from measurements and hardware inputs.
	always_comb begin
		alarm_cond = '0;
		alarm_cond[aem_pkg::ALM_OV] = i_meas.voltage >= ov_limit;
		alarm_cond[aem_pkg::ALM_OC] = i_meas.current >= oc_limit;
		alarm_cond[aem_pkg::ALM_OP] = i_meas.power >= op_limit;
		alarm_cond[aem_pkg::ALM_PF] = i_hw.supply_bad;
		alarm_cond[aem_pkg::ALM_OT] = i_hw.over_temp;
		alarm_cond[aem_pkg::ALM_LINK] = i_hw.slave_lost
			&& ctl[aem_pkg::CTL_MS_MODE];
		alarm_cond[aem_pkg::ALM_SAFE] =
			32'(i_meas.voltage) * 32'(aem_pkg::SAFE_DEN)
			> 32'(NOM_VOLTAGE) * 32'(aem_pkg::SAFE_NUM);
		alarm_cond[aem_pkg::ALM_SHARE] = i_hw.share_weak
			|| (i_hw.share_linked
			&& !ctl[aem_pkg::CTL_MS_MODE]);
		alarm_cond[aem_pkg::ALM_EVENT] = |ev_alarm_hit;
	end

	// Acknowledge requests: panel, remote or write-one to the alarms.
	always_comb begin
		alarm_clr = '0;
		if (i_ack_panel || i_ack_remote) begin
			alarm_clr = '1;
		end
		if (wr_go && dph_addr == aem_pkg::OFS_ALARMS) begin
			alarm_clr = alarm_clr | i_hwdata[8:0];
		end
		if (pf_ack_busy) begin
			alarm_clr[aem_pkg::ALM_PF] = 1'b0;
		end
		// The link alarm ignores acknowledges entirely.
		alarm_clr[aem_pkg::ALM_LINK] = ms_reinit
			|| !ctl[aem_pkg::CTL_MS_MODE];
	end

	// Pending alarm flags; a live condition wins over its clear.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			alarm <= '0;
		end else begin
			alarm <= (alarm & ~alarm_clr) | alarm_cond;
		end
	end

	// ==========================================================
	// User events, checked only while the output is on.
	assign ev_warn_clr = (i_ack_panel || i_ack_remote
		|| (wr_go && dph_addr == aem_pkg::OFS_EVENTS))
		? ((wr_go && dph_addr == aem_pkg::OFS_EVENTS
			&& !i_ack_panel && !i_ack_remote)
			? i_hwdata[5:3] : 3'h7) : 3'h0;

	always_comb begin
		ev_hit = '0;
		ev_hit[aem_pkg::EV_HIGH_VOLT] = i_meas.voltage >= ev_thr[0];
		ev_hit[aem_pkg::EV_LOW_VOLT]  = i_meas.voltage < ev_thr[1];
		ev_hit[aem_pkg::EV_HIGH_CURR] = i_meas.current >= ev_thr[2];
		ev_hit = ev_hit & {3{o_dc_enable}};
	end

	generate
		for (genvar k = 0; k < aem_pkg::EV_COUNT; k++) begin : g_ev
			// Alarm action feeds the shared event alarm flag.
			assign ev_alarm_hit[k] = ev_hit[k]
				&& ev_action(ev_cfg, k) == aem_pkg::ACT_ALARM;

			// Indication follows the condition unless action is none.
			always_ff @(posedge i_clock or negedge i_reset_n) begin
				if (!i_reset_n) begin
					ev_ind[k] <= 1'b0;
				end else begin
					ev_ind[k] <= ev_hit[k]
						&& ev_action(ev_cfg, k)
						!= aem_pkg::ACT_NONE;
				end
			end

			// Warning stays until acknowledged; a hit beats the clear.
			always_ff @(posedge i_clock or negedge i_reset_n) begin
				if (!i_reset_n) begin
					ev_warn[k] <= 1'b0;
				end else if (ev_hit[k] && ev_action(ev_cfg, k)
						== aem_pkg::ACT_WARNING) begin
					ev_warn[k] <= 1'b1;
				end else if (ev_warn_clr[k]) begin
					ev_warn[k] <= 1'b0;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Outputs, each straight from a flip-flop.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_dc_enable    <= 1'b0;
			o_beep         <= 1'b0;
			o_analog_alarm <= 1'b0;
			o_status_ind   <= 1'b0;
			o_warning      <= 1'b0;
		end else begin
			// Output on only with no blocking alarm or supply lock.
			o_dc_enable <= ctl[aem_pkg::CTL_OUTPUT_ON]
				&& !(|((alarm | alarm_cond) & aem_pkg::ALM_OFF_MASK))
				&& !pf_lock_busy;
			o_beep <= ctl[aem_pkg::CTL_BEEP_EN] && |alarm;
			o_analog_alarm <= |(alarm
				& aem_pkg::ALM_ANALOG_MASK);
			o_status_ind <= |ev_ind;
			o_warning    <= |ev_warn;
		end
	end

endmodule : aem_top

// *** dv/aem_top_asserts.sv ***
// Concurrent checks that watch the ports of the alarm and event manager.
module aem_top_asserts #(
	parameter logic [15:0] NOM_VOLTAGE = 16'h2710
) (
	// Clock and reset.
	input wire logic               i_clock,
	input wire logic               i_reset_n,
	// Inputs that cause alarms or clear them.
	input wire aem_pkg::aem_ahb_t  i_ahb,
	input wire aem_pkg::aem_meas_t i_meas,
	input wire aem_pkg::aem_hw_t   i_hw,
	input wire logic               i_ack_panel,
	input wire logic               i_ack_remote,
	// Outputs under watch.
	input wire logic               o_hreadyout,
	input wire logic               o_hresp,
	input wire logic               o_dc_enable,
	input wire logic               o_analog_alarm,
	input wire logic               o_status_ind,
	input wire logic               o_warning
);
	// ==========================================================
	// Shared clocking and helper logic.
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	// High while the voltage is above the rigid safety threshold.
	logic over_safe;
	assign over_safe = 32'(i_meas.voltage) * 32'd100 >
		32'(NOM_VOLTAGE) * 32'd101;

	// ==========================================================
	// Assertions.
	bus_okay_a: assert property (o_hresp == 1'b0)
		else $error("bus response was not okay");
	read_wait_a: assert property (!o_hreadyout |=> o_hreadyout)
		else $error("read wait lasted more than one cycle");
	safe_off_a: assert property (over_safe |=> !o_dc_enable)
		else $error("output stayed on above the safety voltage");
	// The analog line follows the latched flag, two edges after the cause.
	safe_line_a: assert property (over_safe |->
		##2 o_analog_alarm)
		else $error("safety alarm missing on the analog line");
	supply_off_a: assert property (i_hw.supply_bad |=> !o_dc_enable)
		else $error("output stayed on during supply failure");
	temp_off_a: assert property (i_hw.over_temp |=> !o_dc_enable)
		else $error("output stayed on during overtemperature");
	share_flag_a: assert property (i_hw.share_weak |->
		##2 o_analog_alarm)
		else $error("shared bus alarm not raised");
	// A clear lands one edge before the line drops, and a control write
	// needs one more edge through the mode bit or the reinit pulse.
	alarm_hold_a: assert property (o_analog_alarm && !i_ack_panel &&
		!i_ack_remote && !$past(i_ack_panel) && !$past(i_ack_remote) &&
		!i_ahb.hsel && !$past(i_ahb.hsel) && !$past(i_ahb.hsel, 2) &&
		!$past(i_ahb.hsel, 3) |=> o_analog_alarm)
		else $error("alarm cleared without acknowledge");
	pf_lock_a: assert property ($fell(i_hw.supply_bad) |=>
		!o_dc_enable [*8])
		else $error("output returned too soon after supply failure");
	// The hit that raised the output was judged two samples earlier.
	status_on_a: assert property ($rose(o_status_ind) |->
		$past(o_dc_enable, 2))
		else $error("event indicated while output was off");
	warn_on_a: assert property ($rose(o_warning) |->
		$past(o_dc_enable, 2))
		else $error("warning raised while output was off");
endmodule : aem_top_asserts

bind aem_top aem_top_asserts #(.NOM_VOLTAGE(NOM_VOLTAGE)) i_aem_top_asserts (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_ahb(i_ahb),
	.i_meas(i_meas), .i_hw(i_hw), .i_ack_panel(i_ack_panel),
	.i_ack_remote(i_ack_remote), .o_hreadyout(o_hreadyout),
	.o_hresp(o_hresp), .o_dc_enable(o_dc_enable),
	.o_analog_alarm(o_analog_alarm), .o_status_ind(o_status_ind),
	.o_warning(o_warning));

// *** dv/aem_ack_model.sv ***
// Model of the operator panel and remote control that acknowledge alarms.
module aem_ack_model (
	// Clock and reset.
	input  wire logic       i_clock,
	input  wire logic       i_reset_n,
	// Request from the bench: source and answer delay.
	input  wire logic       i_req,
	input  wire logic       i_remote,
	input  wire logic [3:0] i_delay,
	// One-cycle acknowledge pulses.
	output logic            o_ack_panel,
	output logic            o_ack_remote
);
	logic [3:0] wait_cnt;   // Cycles left before the answer.
	logic       busy;       // A request is waiting to be answered.
	logic       via_remote; // Which party answers.
	// Counts the delay down, then pulses the chosen acknowledge line.
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy         <= 1'b0;
			wait_cnt     <= 4'h0;
			via_remote   <= 1'b0;
			o_ack_panel  <= 1'b0;
			o_ack_remote <= 1'b0;
		end else begin
			o_ack_panel  <= 1'b0;
			o_ack_remote <= 1'b0;
			if (i_req) begin
				busy       <= 1'b1;
				wait_cnt   <= i_delay;
				via_remote <= i_remote;
			end else if (busy && wait_cnt == 4'h0) begin
				busy         <= 1'b0;
				o_ack_panel  <= !via_remote;
				o_ack_remote <= via_remote;
			end else if (busy) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end
endmodule : aem_ack_model

// *** dv/aem_top_tb_top.sv ***
// Self-checking testbench of the alarm and event manager.
module aem_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ACKC  = 20; // Shortened acknowledge window.
	localparam int LOCKC = 40; // Shortened output lock time.
	// ==========================================================
	// Signals.
	logic i_clock, i_reset_n, hsel, hwrite, req, remote, rd_phase;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, o_hrdata;
	logic [3:0] delay;
	aem_pkg::aem_ahb_t  ahb;
	aem_pkg::aem_meas_t meas;
	aem_pkg::aem_hw_t   hw;
	logic ack_panel, ack_remote, o_hreadyout, o_hresp, o_dc_enable;
	logic o_beep, o_analog_alarm, o_status_ind, o_warning;
	logic [31:0] exp_q[$]; // Expected read data, oldest first.
	int fail_count, checks_done, cycles;
	assign ahb = {hsel, htrans, hwrite, 3'h2, haddr, o_hreadyout};

	aem_top #(.PF_ACK_CYC(32'(ACKC)), .PF_LOCK_CYC(32'(LOCKC))) i_aem_top (
		.i_clock(i_clock), .i_reset_n(i_reset_n), .i_ahb(ahb),
		.i_hwdata(hwdata), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp), .i_meas(meas), .i_hw(hw),
		.i_ack_panel(ack_panel), .i_ack_remote(ack_remote),
		.o_dc_enable(o_dc_enable), .o_beep(o_beep),
		.o_analog_alarm(o_analog_alarm), .o_status_ind(o_status_ind),
		.o_warning(o_warning));
	aem_ack_model i_aem_ack_model (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_req(req), .i_remote(remote), .i_delay(delay),
		.o_ack_panel(ack_panel), .o_ack_remote(ack_remote));

	// ==========================================================
	// Clock, timeout and read monitor.
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end
	// Takes the oldest note when read data completes.
	always @(posedge i_clock) begin
		if (rd_phase === 1'b1 && o_hreadyout === 1'b1) begin
			check_word(o_hrdata, exp_q.pop_front());
		end
	end

	// ==========================================================
	// Tasks.
	task automatic check_word(input logic [31:0] got, input logic [31:0] e);
		checks_done++;
		if (got !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, e);
		end
	endtask : check_word
	task automatic check_bit(input logic got, input logic e);
		check_word({31'h0, got}, {31'h0, e});
	endtask : check_bit
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask : cyc
	// One single word transfer, address phase then data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr  <= {24'h0, a};
		do @(posedge i_clock); while (o_hreadyout !== 1'b1);
		hsel     <= 1'b0;
		htrans   <= 2'h0;
		hwdata   <= d;
		rd_phase <= !wr;
		do @(posedge i_clock); while (o_hreadyout !== 1'b1);
		rd_phase <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// Remote answers slowly, the panel promptly.
	task automatic ack(input logic r);
		req    <= 1'b1;
		remote <= r;
		delay  <= r ? 4'h6 : 4'h0;
		@(posedge i_clock);
		req <= 1'b0;
		cyc(r ? 9 : 3);
	endtask : ack
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	// ==========================================================
	// Main sequence.
	initial begin
		{i_reset_n, hsel, hwrite, req, remote, rd_phase} = 6'h0;
		{htrans, haddr, hwdata, delay} = '0;
		meas = '0;
		hw = '0;
		{fail_count, checks_done, cycles} = '0;
		void'($urandom(33));
		cyc(2);
		i_reset_n <= 1'b1;
		rd(aem_pkg::OFS_CONTROL, 32'h0);
		for (int k = 0; k < 3; k++) begin
			rd(aem_pkg::OFS_OV_LIMIT + 8'(4 * k), 32'h0000_2AF8);
		end
		rd(aem_pkg::OFS_EVENT_CFG, 32'h0);
		rd(8'h30, 32'h0);
		wr(aem_pkg::OFS_OV_LIMIT, 32'h0000_FFFF);
		rd(aem_pkg::OFS_OV_LIMIT, 32'h0000_2AF8);
		$display("test reset values done");
		wr(aem_pkg::OFS_CONTROL, 32'h3);
		for (int k = 0; k < 3; k++) begin
			wr(aem_pkg::OFS_OV_LIMIT + 8'(4 * k), 32'h0000_1000);
			meas <= 48'($urandom_range(32'h0FFF)) << (32 - 16 * k);
			cyc(2);
			check_bit(o_dc_enable, 1'b1);
			meas <= 48'h1000 << (32 - 16 * k);
			cyc(3);
			check_bit(o_dc_enable, 1'b0);
			check_bit(o_beep, 1'b1);
			meas <= '0;
			cyc(3);
			rd(aem_pkg::OFS_ALARMS, 32'h1 << k);
			ack(k[0]);
			rd(aem_pkg::OFS_ALARMS, 32'h0);
			wr(aem_pkg::OFS_CONTROL, 32'h3);
		end
		$display("test limit trips done");
		hw.over_temp <= 1'b1;
		cyc(2);
		check_bit(o_dc_enable, 1'b0);
		hw.over_temp <= 1'b0;
		ack(1'b0);
		rd(aem_pkg::OFS_ALARMS, 32'h0);
		wr(aem_pkg::OFS_CONTROL, 32'h7);
		hw.share_weak <= 1'b1;
		cyc(3);
		check_bit(o_analog_alarm, 1'b1);
		check_bit(o_dc_enable, 1'b1);
		hw.share_weak <= 1'b0;
		hw.slave_lost <= 1'b1;
		cyc(2);
		check_bit(o_dc_enable, 1'b0);
		hw.slave_lost <= 1'b0;
		ack(1'b1);
		rd(aem_pkg::OFS_ALARMS, 32'h0000_0020);
		wr(aem_pkg::OFS_CONTROL, 32'h0000_0024);
		rd(aem_pkg::OFS_ALARMS, 32'h0);
		hw.slave_lost <= 1'b1;
		cyc(2);
		hw.slave_lost <= 1'b0;
		rd(aem_pkg::OFS_ALARMS, 32'h0000_0020);
		wr(aem_pkg::OFS_CONTROL, 32'h0);
		cyc(2);
		rd(aem_pkg::OFS_ALARMS, 32'h0);
		hw.share_linked <= 1'b1;
		cyc(2);
		hw.share_linked <= 1'b0;
		rd(aem_pkg::OFS_ALARMS, 32'h0000_0080);
		ack(1'b0);
		$display("test hardware alarms done");
		wr(aem_pkg::OFS_CONTROL, 32'h3);
		hw.supply_bad <= 1'b1;
		cyc(3);
		check_bit(o_dc_enable, 1'b0);
		hw.supply_bad <= 1'b0;
		cyc(2);
		ack(1'b0);
		rd(aem_pkg::OFS_ALARMS, 32'h0000_0008);
		rd(aem_pkg::OFS_STATE, 32'h0000_0006);
		cyc(16);
		ack(1'b0);
		rd(aem_pkg::OFS_ALARMS, 32'h0);
		rd(aem_pkg::OFS_STATE, 32'h0000_0004);
		wr(aem_pkg::OFS_CONTROL, 32'h3);
		cyc(2);
		check_bit(o_dc_enable, 1'b0);
		cyc(LOCKC);
		check_bit(o_dc_enable, 1'b1);
		$display("test supply failure done");
		wr(aem_pkg::OFS_EV_HV_THR, 32'h0000_0800);
		for (int a = 0; a < 4; a++) begin
			wr(aem_pkg::OFS_EVENT_CFG, 32'(a));
			meas.voltage <= 16'h0800 + 16'($urandom_range(32'h03FF));
			cyc(5);
			check_bit(o_status_ind, a == 1 || a == 2);
			check_bit(o_warning, a == 2);
			check_bit(o_dc_enable, a != 3);
			check_bit(o_analog_alarm, 1'b0);
			meas.voltage <= 16'h0000;
			cyc(2);
			check_bit(o_warning, a == 2);
			rd(aem_pkg::OFS_ALARMS, a == 3 ? 32'h100 : 32'h0);
			ack(a[0]);
			cyc(1);
			check_bit(o_warning, 1'b0);
			wr(aem_pkg::OFS_CONTROL, 32'h3);
		end
		$display("test user events done");
		wr(aem_pkg::OFS_EVENT_CFG, 32'h0);
		wr(aem_pkg::OFS_OV_LIMIT, 32'h0000_FFFF);
		meas.voltage <= 16'h2774;
		cyc(3);
		check_bit(o_dc_enable, 1'b1);
		meas.voltage <= 16'h2775;
		cyc(2);
		check_bit(o_dc_enable, 1'b0);
		meas.voltage <= 16'h0000;
		rd(aem_pkg::OFS_ALARMS, 32'h0000_0040);
		$display("test safety voltage done");
		summarize();
	end
endmodule : aem_top_tb_top
